//--- verilog/rrs_supervisor.v
// receive retransmission request supervisor with AXI4-Lite configuration
//
// Contract
// RULE_01: short timer counts words from request
// RULE_02: long nonzero: short phase ignores errors, discontinuities
// RULE_03: long zero: short phase ignores errors only
// RULE_04: long zero: short expiry re-requests
// RULE_05: software sets short limit above latency
// RULE_06: software sets short limit above eight
// RULE_07: long timer counts words, default zero
// RULE_08: software sets long zero or above latency
// RULE_09: long expiry without discontinuity re-requests
// RULE_10: re-request tally at maximum flags retry error
// RULE_11: software sets retry maximum two or more
// RULE_12: wrap timer counts sequence changes, zero disables
// RULE_13: wrap flag sticky until clear pulsed
// RULE_14: watchdog counts words, limit from msbs
// RULE_15: watchdog disabled when msbs all zero
// RULE_16: watchdog flag sticky until clear pulsed
// RULE_17: watchdog lsbs zero; timers restart on arrival
`timescale 1ns/10ps
`include "rrs_defines.vh"

module rrs_supervisor (
	input wire aclk,
	input wire aresetn,
	// link side events, one cycle each
	input wire word_valid,
	input wire crc_error,
	input wire seq_discontinuity,
	input wire primary_seq_change,
	input wire expected_seq_arrived,
	output reg retrans_request,
	output reg rerequest_exhausted_flag,
	output reg seq_wrap_error_flag,
	output reg watchdog_expired_flag,
	// AXI4-Lite slave
	input wire [`RRS_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`RRS_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// =====================================================================
	// configuration registers
	reg retrans_error_clear, clear_prev;
	reg [`RRS_SHORT_W-1:0] short_timer_limit;
	reg [`RRS_LONG_W-1:0] long_timer_limit;
	reg [`RRS_RETRY_W-1:0] rerequest_max;
	reg [`RRS_WRAP_W-1:0] seq_wrap_limit;
	reg [`RRS_WDOG_MSB_W-1:0] watchdog_limit_msbs;

	// write channel holding; w_old is the addressed configuration register as it reads back, zero for status
	reg [`RRS_ADDR_W-1:0] aw_addr;
	reg [31:0] w_data, w_old;
	reg [3:0] w_strb;
	wire [31:0] w_merged;

	// supervisor state
	reg [1:0] state, next_state;
	reg [`RRS_RETRY_W-1:0] retry_cnt, next_retry_cnt;
	reg next_request, retry_hit;

	wire mode_short_only, short_reached, long_reached, wrap_reached, wdog_reached;
	wire supervising, timer_restart, hold_restart, clear_release;
	wire wrap_enabled, wdog_enabled, wrap_hit, wdog_hit, write_fire;
	wire [`RRS_WDOG_W-1:0] wdog_limit;
	wire [31:0] status_word;

	// byte lanes not strobed keep the register's old contents
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign w_merged[lane*8 +: 8] = w_strb[lane] ? w_data[lane*8 +: 8] : w_old[lane*8 +: 8];
		end
	endgenerate

	always @* begin
		case (aw_addr)
			`RRS_OFF_CTRL: w_old = {31'h00000000, retrans_error_clear};
			`RRS_OFF_SHORT: w_old = {16'h0000, short_timer_limit};
			`RRS_OFF_LONG: w_old = {16'h0000, long_timer_limit};
			`RRS_OFF_RETRY: w_old = {28'h0000000, rerequest_max};
			`RRS_OFF_WRAP: w_old = {24'h000000, seq_wrap_limit};
			`RRS_OFF_WDOG: w_old = {20'h00000, watchdog_limit_msbs};
			default: w_old = 32'h00000000;
		endcase
	end

	// =====================================================================
	// derived controls
	assign mode_short_only = (long_timer_limit == `RRS_RST_LONG);
	assign supervising = (state != `RRS_ST_IDLE);
	assign wdog_limit = {watchdog_limit_msbs, `RRS_WDOG_LSBS}; // [RULE_17]
	assign wrap_enabled = (seq_wrap_limit != `RRS_RST_WRAP); // [RULE_12]
	assign wdog_enabled = (watchdog_limit_msbs != `RRS_RST_WDOG); // [RULE_15]
	assign wrap_hit = wrap_enabled && supervising && wrap_reached; // [RULE_13]
	assign wdog_hit = wdog_enabled && supervising && wdog_reached; // [RULE_16]
	// the request timers restart with every request or re-request
	assign timer_restart = next_request || !supervising;
	// the waiting timers restart once the expected sequence is back and stay cleared while idle
	assign hold_restart = !supervising || expected_seq_arrived; // [RULE_17]
	assign clear_release = clear_prev && !retrans_error_clear;
	assign write_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	assign status_word = {20'h00000, retry_cnt, 2'h0, state, 1'b0,
		watchdog_expired_flag, seq_wrap_error_flag, rerequest_exhausted_flag};

	// =====================================================================
	// timers
	rrs_word_counter #(.WIDTH(`RRS_SHORT_W)) u_short (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(timer_restart),
		.step(word_valid && (state == `RRS_ST_SHORT)), // [RULE_01]
		.limit(short_timer_limit),
		.reached(short_reached)
	);

	// the long timer keeps counting through the short phase
	rrs_word_counter #(.WIDTH(`RRS_LONG_W)) u_long (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(timer_restart),
		.step(word_valid && !mode_short_only && supervising && (state != `RRS_ST_AWAIT)), // [RULE_07]
		.limit(long_timer_limit),
		.reached(long_reached)
	);

	rrs_word_counter #(.WIDTH(`RRS_WRAP_W)) u_wrap (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(hold_restart),
		.step(primary_seq_change && wrap_enabled), // [RULE_12]
		.limit(seq_wrap_limit),
		.reached(wrap_reached)
	);

	rrs_word_counter #(.WIDTH(`RRS_WDOG_W)) u_wdog (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(hold_restart),
		.step(word_valid && wdog_enabled), // [RULE_14]
		.limit(wdog_limit),
		.reached(wdog_reached)
	);

	// =====================================================================
	// request sequencing
	always @* begin
		next_state = state;
		next_retry_cnt = retry_cnt;
		next_request = 1'b0;
		retry_hit = 1'b0;
		case (state)
			`RRS_ST_IDLE: begin
				if (crc_error) begin
					next_state = `RRS_ST_SHORT; // [RULE_01] [RULE_07]
					next_request = 1'b1;
					next_retry_cnt = {`RRS_RETRY_W{1'b0}};
				end
			end
			`RRS_ST_SHORT: begin
				// errors are never looked at here
				if (mode_short_only) begin
					if (seq_discontinuity) begin
						next_state = `RRS_ST_AWAIT; // [RULE_03]
					end else if (short_reached) begin
						next_request = 1'b1; // [RULE_04]
					end
				end else if (short_reached) begin
					next_state = `RRS_ST_LONG; // [RULE_02]
				end
			end
			`RRS_ST_LONG: begin
				if (seq_discontinuity) begin
					next_state = `RRS_ST_AWAIT;
				end else if (long_reached) begin
					next_state = `RRS_ST_SHORT;
					next_request = 1'b1; // [RULE_09]
				end
			end
			`RRS_ST_AWAIT: next_state = `RRS_ST_AWAIT;
			default: next_state = `RRS_ST_IDLE;
		endcase
		// a re-request bumps the tally; at the maximum stop asking and wait
		if (next_request && supervising) begin
			next_retry_cnt = retry_cnt + {{(`RRS_RETRY_W-1){1'b0}}, 1'b1};
			if (next_retry_cnt >= rerequest_max) begin
				retry_hit = 1'b1; // [RULE_10]
				next_state = `RRS_ST_AWAIT;
			end
		end
		if (supervising && expected_seq_arrived) begin
			next_state = `RRS_ST_IDLE; // [RULE_17]
			next_request = 1'b0;
			retry_hit = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= `RRS_ST_IDLE;
			retry_cnt <= {`RRS_RETRY_W{1'b0}};
			retrans_request <= 1'b0;
		end else begin
			state <= next_state;
			retry_cnt <= next_retry_cnt;
			retrans_request <= next_request;
		end
	end

	// =====================================================================
	// sticky error flags; a new hit in the release cycle wins over the clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			clear_prev <= 1'b0;
			rerequest_exhausted_flag <= 1'b0;
			seq_wrap_error_flag <= 1'b0;
			watchdog_expired_flag <= 1'b0;
		end else begin
			clear_prev <= retrans_error_clear;
			if (retry_hit) begin
				rerequest_exhausted_flag <= 1'b1; // [RULE_10]
			end else if (clear_release) begin
				rerequest_exhausted_flag <= 1'b0;
			end
			if (wrap_hit) begin
				seq_wrap_error_flag <= 1'b1; // [RULE_13]
			end else if (clear_release) begin
				seq_wrap_error_flag <= 1'b0; // [RULE_13]
			end
			if (wdog_hit) begin
				watchdog_expired_flag <= 1'b1; // [RULE_16]
			end else if (clear_release) begin
				watchdog_expired_flag <= 1'b0; // [RULE_16]
			end
		end
	end

	// =====================================================================
	// AXI4-Lite write path: address and data are latched in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RRS_RESP_OKAY;
			aw_addr <= {`RRS_ADDR_W{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			retrans_error_clear <= 1'b0;
			short_timer_limit <= `RRS_RST_SHORT;
			long_timer_limit <= `RRS_RST_LONG;
			rerequest_max <= `RRS_RST_RETRY;
			seq_wrap_limit <= `RRS_RST_WRAP;
			watchdog_limit_msbs <= `RRS_RST_WDOG;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (write_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RRS_RESP_OKAY;
				case (aw_addr)
					`RRS_OFF_CTRL: retrans_error_clear <= w_merged[`RRS_CTRL_CLEAR_BIT];
					`RRS_OFF_SHORT: short_timer_limit <= w_merged[`RRS_SHORT_W-1:0];
					`RRS_OFF_LONG: long_timer_limit <= w_merged[`RRS_LONG_W-1:0];
					`RRS_OFF_RETRY: rerequest_max <= w_merged[`RRS_RETRY_W-1:0];
					`RRS_OFF_WRAP: seq_wrap_limit <= w_merged[`RRS_WRAP_W-1:0];
					`RRS_OFF_WDOG: watchdog_limit_msbs <= w_merged[`RRS_WDOG_MSB_W-1:0];
					// read only; writes are accepted and dropped
					`RRS_OFF_STATUS: s_axi_bresp <= `RRS_RESP_OKAY;
					default: s_axi_bresp <= `RRS_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// =====================================================================
	// AXI4-Lite read path
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RRS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RRS_RESP_OKAY;
				case (s_axi_araddr)
					`RRS_OFF_CTRL: s_axi_rdata <= {31'h00000000, retrans_error_clear};
					`RRS_OFF_SHORT: s_axi_rdata <= {16'h0000, short_timer_limit};
					`RRS_OFF_LONG: s_axi_rdata <= {16'h0000, long_timer_limit};
					`RRS_OFF_RETRY: s_axi_rdata <= {28'h0000000, rerequest_max};
					`RRS_OFF_WRAP: s_axi_rdata <= {24'h000000, seq_wrap_limit};
					`RRS_OFF_WDOG: s_axi_rdata <= {20'h00000, watchdog_limit_msbs};
					`RRS_OFF_STATUS: s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RRS_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

//--- verilog/rrs_defines.vh
// constants for the receive retransmission request supervisor
`ifndef RRS_DEFINES_VH
`define RRS_DEFINES_VH

// =====================================================================
// register byte offsets on the AXI4-Lite port
`define RRS_ADDR_W 8
`define RRS_OFF_CTRL 8'h00
`define RRS_OFF_SHORT 8'h04
`define RRS_OFF_LONG 8'h08
`define RRS_OFF_RETRY 8'h0C
`define RRS_OFF_WRAP 8'h10
`define RRS_OFF_WDOG 8'h14
`define RRS_OFF_STATUS 8'h18

// =====================================================================
// field widths
`define RRS_SHORT_W 16
`define RRS_LONG_W 16
`define RRS_RETRY_W 4
`define RRS_WRAP_W 8
`define RRS_WDOG_MSB_W 12
`define RRS_WDOG_W 32
`define RRS_WDOG_LSB_W 20

// =====================================================================
// reset values of the configuration fields
`define RRS_RST_SHORT 16'h0800
`define RRS_RST_LONG 16'h0000
`define RRS_RST_RETRY 4'h2
`define RRS_RST_WRAP 8'h00
`define RRS_RST_WDOG 12'h000
`define RRS_WDOG_LSBS 20'h00000

// =====================================================================
// control and status field positions
`define RRS_CTRL_CLEAR_BIT 0
`define RRS_STAT_RETRY_BIT 0
`define RRS_STAT_WRAP_BIT 1
`define RRS_STAT_WDOG_BIT 2
`define RRS_STAT_STATE_LSB 4
`define RRS_STAT_STATE_MSB 5
`define RRS_STAT_CNT_LSB 8
`define RRS_STAT_CNT_MSB 11

// =====================================================================
// supervisor states
`define RRS_ST_IDLE 2'h0
`define RRS_ST_SHORT 2'h1
`define RRS_ST_LONG 2'h2
`define RRS_ST_AWAIT 2'h3

// =====================================================================
// bus answers
`define RRS_RESP_OKAY 2'h0
`define RRS_RESP_SLVERR 2'h2

`endif

//--- verilog/rrs_word_counter.v
// saturating event counter with synchronous restart and limit compare
`timescale 1ns/10ps

module rrs_word_counter #(
	parameter WIDTH = 16
) (
	input wire aclk,
	input wire aresetn,
	input wire restart,
	input wire step,
	input wire [WIDTH-1:0] limit,
	output wire reached
);

	reg [WIDTH-1:0] count;

	// saturating at the limit keeps reached high until a restart
	assign reached = (count == limit);

	// =====================================================================
	// counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= {WIDTH{1'b0}};
		end else if (restart) begin
			count <= {WIDTH{1'b0}};
		end else if (step && !reached) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

//--- verif/rrs_supervisor_props.sv
// assertion checker for the retransmission request supervisor
`timescale 1ns/10ps
`include "rrs_defines.vh"

module rrs_supervisor_props (
	input wire aclk,
	input wire aresetn,
	input wire retrans_request,
	input wire rerequest_exhausted_flag,
	input wire seq_wrap_error_flag,
	input wire watchdog_expired_flag,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`RRS_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// =====================================================================
	// properties, all in the single clock domain
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// short limit above eight keeps two requests apart
	a_req_one_cycle: assert property (retrans_request |=> !retrans_request) else $error("request too long");
	a_retry_with_req: assert property ($rose(rerequest_exhausted_flag) |-> retrans_request)
		else $error("retry flag without request");
	a_retry_sticky: assert property ($fell(rerequest_exhausted_flag) |-> $past(s_axi_bvalid))
		else $error("retry flag dropped");
	a_wrap_sticky: assert property ($fell(seq_wrap_error_flag) |-> $past(s_axi_bvalid))
		else $error("wrap flag dropped");
	a_wdog_sticky: assert property (watchdog_expired_flag && !s_axi_bvalid |=> watchdog_expired_flag)
		else $error("watchdog flag dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `RRS_OFF_STATUS
		|=> s_axi_rresp == `RRS_RESP_SLVERR && s_axi_rdata == 32'h00000000) else $error("unmapped read");
	c_rerequest: cover property (retrans_request ##10 retrans_request);
	c_retry_flag: cover property ($rose(rerequest_exhausted_flag));
	c_wrap_flag: cover property ($rose(seq_wrap_error_flag));
endmodule

bind rrs_supervisor rrs_supervisor_props i_props (.aclk(aclk), .aresetn(aresetn), .retrans_request(retrans_request),
	.rerequest_exhausted_flag(rerequest_exhausted_flag), .seq_wrap_error_flag(seq_wrap_error_flag),
	.watchdog_expired_flag(watchdog_expired_flag), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- verif/rrs_partner_model.sv
// link partner model that answers the latest request with one discontinuity after a nonzero latency
`timescale 1ns/10ps

module rrs_partner_model (
	input wire aclk,
	input wire aresetn,
	input wire retrans_request,
	input wire [7:0] latency,
	output reg seq_discontinuity
);
	// =====================================================================
	// answer timer; latency zero models a partner that never answers
	reg [7:0] left;
	always @(posedge aclk) begin
		if (!aresetn) begin
			left <= 8'h00;
			seq_discontinuity <= 1'b0;
		end else if (retrans_request && latency != 8'h00) begin
			left <= latency;
			seq_discontinuity <= 1'b0;
		end else begin
			left <= (left != 8'h00) ? left - 8'h01 : 8'h00;
			seq_discontinuity <= (left == 8'h01);
		end
	end
endmodule

//--- verif/tb.sv
// self-checking bench for the retransmission request supervisor
`timescale 1ns/10ps
`include "rrs_defines.vh"

module tb;
	// =====================================================================
	// signals
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg word_valid = 1'b0;
	reg crc_error = 1'b0;
	reg primary_seq_change = 1'b0;
	reg expected_seq_arrived = 1'b0;
	reg [7:0] lat = 8'h00;
	reg [7:0] awaddr = 8'h00;
	reg [7:0] araddr = 8'h00;
	reg [31:0] wdata = 32'h00000000;
	reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, seq_discontinuity, retrans_request;
	wire retry_flag, wrap_flag, wdog_flag;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	reg [1:0] resp;
	reg [31:0] rd;
	int cyc = 0;
	int num_errors = 0;
	int total_checks = 0;
	int stamps[$];

	always #2 aclk = ~aclk;

	rrs_supervisor i_dut (.aclk(aclk), .aresetn(aresetn), .word_valid(word_valid), .crc_error(crc_error),
		.seq_discontinuity(seq_discontinuity), .primary_seq_change(primary_seq_change),
		.expected_seq_arrived(expected_seq_arrived), .retrans_request(retrans_request),
		.rerequest_exhausted_flag(retry_flag), .seq_wrap_error_flag(wrap_flag), .watchdog_expired_flag(wdog_flag),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	rrs_partner_model i_partner (.aclk(aclk), .aresetn(aresetn), .retrans_request(retrans_request),
		.latency(lat), .seq_discontinuity(seq_discontinuity));

	// =====================================================================
	// request time stamps and hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (retrans_request === 1'b1) stamps.push_back(cyc);
		if (cyc == 5000) begin
			num_errors = num_errors + 1;
			report_and_stop();
		end
	end

	// =====================================================================
	// shared tasks
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdreg(input [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// k: bit2 crc error, bit1 sequence change, bit0 expected arrival
	task automatic ev(input [2:0] k);
		@(posedge aclk);
		{crc_error, primary_seq_change, expected_seq_arrived} <= k;
		@(posedge aclk);
		{crc_error, primary_seq_change, expected_seq_arrived} <= 3'h0;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic clear_flags;
		wr(`RRS_OFF_CTRL, 32'h00000001);
		wr(`RRS_OFF_CTRL, 32'h00000000);
		wait_cyc(2);
	endtask

	// =====================================================================
	// scenarios
	task automatic t_regs;
		logic [31:0] exp [5] = '{32'h00000800, 32'h00000000, 32'h00000002, 32'h00000000, 32'h00000000};
		for (int i = 0; i < 5; i++) begin
			rdreg(`RRS_OFF_SHORT + 8'(4 * i));
			chk(rd, exp[i]);
		end
		rdreg(8'h1C);
		chk(resp, `RRS_RESP_SLVERR);
		wr(8'h20, 32'h00000001);
		chk(resp, `RRS_RESP_SLVERR);
		wr(`RRS_OFF_WDOG, 32'hFFFFFFFF);
		rdreg(`RRS_OFF_WDOG);
		chk(rd, 32'h00000FFF);
		wr(`RRS_OFF_WDOG, 32'h00000000);
	endtask

	task automatic t_mode2_retry;
		wr(`RRS_OFF_SHORT, 32'h00000009);
		stamps.delete();
		ev(3'h4);
		wait_cyc(4);
		ev(3'h4);
		wait_cyc(40);
		chk(stamps.size(), 3);
		chk(stamps[1] - stamps[0], 10);
		chk(stamps[2] - stamps[1], 10);
		chk(retry_flag, 1'b1);
		rdreg(`RRS_OFF_STATUS);
		chk(rd, 32'h00000231);
		ev(3'h1);
		clear_flags();
		chk(retry_flag, 1'b0);
	endtask

	task automatic t_accept_wrap;
		lat <= 8'h04;
		stamps.delete();
		ev(3'h4);
		wait_cyc(30);
		chk(stamps.size(), 1);
		repeat (5) ev(3'h2);
		wait_cyc(3);
		chk(wrap_flag, 1'b0);
		chk(wdog_flag, 1'b0);
		ev(3'h1);
		wr(`RRS_OFF_WRAP, 32'h00000003);
		ev(3'h4);
		repeat (2) ev(3'h2);
		wait_cyc(3);
		chk(wrap_flag, 1'b0);
		ev(3'h2);
		wait_cyc(3);
		chk(wrap_flag, 1'b1);
		ev(3'h1);
		wr(`RRS_OFF_CTRL, 32'h00000001);
		wait_cyc(2);
		chk(wrap_flag, 1'b1);
		wr(`RRS_OFF_CTRL, 32'h00000000);
		wait_cyc(2);
		chk(wrap_flag, 1'b0);
	endtask

	// discontinuities land in the short phase and must not end the wait
	task automatic t_mode1;
		wr(`RRS_OFF_LONG, 32'h00000014);
		wr(`RRS_OFF_RETRY, 32'h00000002);
		stamps.delete();
		ev(3'h4);
		wait_cyc(70);
		chk(stamps.size(), 3);
		chk(stamps[1] - stamps[0], 21);
		chk(stamps[2] - stamps[1], 21);
		chk(retry_flag, 1'b1);
		ev(3'h1);
		clear_flags();
		// a discontinuity in the long phase ends the wait without a re-request
		lat <= 8'h0F;
		stamps.delete();
		ev(3'h4);
		wait_cyc(30);
		chk(stamps.size(), 1);
		rdreg(`RRS_OFF_STATUS);
		chk(rd, 32'h00000030);
		ev(3'h1);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		word_valid <= 1'b1;
		t_regs();
		t_mode2_retry();
		t_accept_wrap();
		t_mode1();
		report_and_stop();
	end
endmodule
